// ===== verilog/fpc_console.sv
`timescale 1ns/10ps
module fpc_console (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic key_reset_in,
  input wire logic key_start_in,
  input wire logic key_stop_in,
  input wire logic key_continue_in,
  input wire logic key_deposit_in,
  input wire logic key_examine_in,
  input wire logic key_deposit_next_in,
  input wire logic key_examine_next_in,
  input wire logic key_execute_in,
  input wire logic sw_repeat_in,
  input wire logic sw_speed_slow_in,
  input wire logic [fpc_pkg::ADDR_W-1:0] sw_address_in,
  input wire logic [fpc_pkg::WORD_W-1:0] sw_data_in,
  input wire logic [fpc_pkg::ADDR_W-1:0] mem_top_in,
  input wire logic mem_addr_ack_in,
  input wire logic [fpc_pkg::WORD_W-1:0] mem_rdata_in,
  output logic mem_request_out,
  output logic mem_write_out,
  output logic [fpc_pkg::WORD_W-1:0] mem_wdata_out,
  output logic [fpc_pkg::ADDR_W-1:0] memory_address_out,
  output logic [fpc_pkg::ADDR_W-1:0] console_address_out,
  output logic [fpc_pkg::WORD_W-1:0] memory_buffer_out,
  output logic [fpc_pkg::WORD_W-1:0] accumulator_out,
  output logic [fpc_pkg::WORD_W-1:0] instruction_out,
  output logic [fpc_pkg::ADDR_W-1:0] program_counter_out,
  output logic link_out,
  output logic run_out,
  output logic fetch_lamp_out,
  output logic execute_lamp_out,
  output logic [1:0] time_state_out
);
  import fpc_pkg::*;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  // Keys, switches and the memory answer are asynchronous pins.
  localparam int SYN_W = 13 + ADDR_W + WORD_W + ADDR_W + WORD_W;
  logic [SYN_W-1:0] sync_a;
  logic [SYN_W-1:0] sync_b;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {key_reset_in, key_start_in, key_stop_in, key_continue_in, key_deposit_in,
                 key_examine_in, key_deposit_next_in, key_examine_next_in, key_execute_in,
                 sw_repeat_in, sw_speed_slow_in, mem_addr_ack_in, 1'b0,
                 sw_address_in, sw_data_in, mem_top_in, mem_rdata_in};
      sync_b <= sync_a;
    end
  end
  logic k_reset, k_start, k_stop, k_cont, k_dep, k_exam, k_depn, k_examn, k_exec;
  logic s_repeat, s_slow, m_ack, unused_bit;
  logic [ADDR_W-1:0] s_addr, s_top;
  logic [WORD_W-1:0] s_data, m_rdata;
  assign {k_reset, k_start, k_stop, k_cont, k_dep, k_exam, k_depn, k_examn, k_exec,
          s_repeat, s_slow, m_ack, unused_bit, s_addr, s_data, s_top, m_rdata} = sync_b;

  // Edge detect on keys so that a held key fires once, repeat aside.
  logic [8:0] keys_prev;
  logic [8:0] keys_now;
  logic [8:0] key_rise;
  assign keys_now = {k_reset, k_start, k_stop, k_cont, k_dep, k_exam, k_depn, k_examn, k_exec};
  assign key_rise = keys_now & ~keys_prev;

  // ==========================================================
  // Processor and console state
  // ==========================================================
  fpc_state_type state, next_state;
  fpc_major_type major, next_major;
  fpc_op_type op, next_op;
  logic [1:0] ts, next_ts;
  logic run, next_run;
  logic req, next_req;
  logic wr, next_wr;
  logic link, next_link;
  logic [WORD_W-1:0] ir, next_ir, mb, next_mb, ac, next_ac;
  logic [ADDR_W-1:0] pc, next_pc, mo, next_mo, oa, next_oa;
  logic [15:0] rep_cnt, next_rep_cnt;
  logic [15:0] rep_limit;
  logic rep_fire;
  logic [4:0] opc;
  logic ack_prev;
  logic ack_rise;
  logic stop_pend, next_stop_pend;
  logic fetch_lamp, next_fetch_lamp;
  logic execute_lamp, next_execute_lamp;

  assign rep_limit = s_slow ? REPEAT_SLOW : REPEAT_FAST;
  assign rep_fire = s_repeat && (rep_cnt >= rep_limit);
  // Decode from the instruction register, since the buffer also carries operands.
  assign opc = ir[OPC_MSB:OPC_LSB];
  // The synchronised acknowledge lingers after the request drops, so only its rising
  // edge may close a memory cycle; a level test would take the previous answer.
  assign ack_rise = m_ack && !ack_prev;

  always_comb begin
    next_state = state;
    next_major = major;
    next_op = op;
    next_ts = ts;
    next_run = run;
    next_req = req;
    next_wr = wr;
    next_link = link;
    next_ir = ir;
    next_mb = mb;
    next_ac = ac;
    next_pc = pc;
    next_mo = mo;
    next_oa = oa;
    next_rep_cnt = (s_repeat && state == FPC_IDLE && !rep_fire) ? rep_cnt + 16'h0001 : 16'h0000;
    // A short stop press may fall inside a long memory wait, so it is held until T3.
    next_stop_pend = stop_pend
                     || (key_rise[6] && run && state inside {FPC_RUN_T1, FPC_RUN_T2, FPC_RUN_T3});
    case (state)
      FPC_IDLE: begin
        // Console keys only act while halted; repeat re-fires a held deposit, examine or execute key.
        if (key_rise[8]) begin
          next_major = FPC_EXECUTE;
          next_ts = TS_THREE;
          next_ir = WORD_ZERO;
          next_mb = WORD_ZERO;
          next_ac = WORD_ZERO;
          next_pc = ADDR_ZERO;
          next_link = 1'b0;
          next_mo = ADDR_ZERO;
        end else if (key_rise[7] || key_rise[5]) begin
          if (key_rise[7]) begin
            next_pc = s_addr;
            next_mo = s_addr;
          end
          next_run = 1'b1;
          next_major = FPC_FETCH;
          next_state = FPC_RUN_T1;
        end else if (key_rise[4] || (rep_fire && k_dep)) begin
          next_mb = s_data;
          next_oa = s_addr;
          next_mo = s_addr;
          next_op = FPC_OP_DEP;
          next_wr = 1'b1;
          next_req = 1'b1;
          next_state = FPC_MEM_REQ;
        end else if (key_rise[3] || (rep_fire && k_exam)) begin
          next_oa = s_addr;
          next_mo = s_addr;
          next_op = FPC_OP_EXAM;
          next_wr = 1'b0;
          next_req = 1'b1;
          next_state = FPC_MEM_REQ;
        end else if (key_rise[2] || (rep_fire && k_depn)) begin
          next_mb = s_data;
          next_oa = oa + ADDR_ONE;
          next_mo = oa + ADDR_ONE;
          next_op = FPC_OP_DEPN;
          next_wr = 1'b1;
          next_state = FPC_MEM_REQ;
          if (oa + ADDR_ONE > s_top) begin
            next_mb = WORD_ZERO;
            next_major = FPC_FETCH;
            next_ts = TS_TWO;
            next_run = 1'b1;
            next_wr = 1'b0;
            next_state = FPC_HUNG;
          end else begin
            next_req = 1'b1;
          end
        end else if (key_rise[1] || (rep_fire && k_examn)) begin
          next_oa = oa + ADDR_ONE;
          next_mo = oa + ADDR_ONE;
          next_op = FPC_OP_EXAMN;
          next_wr = 1'b0;
          next_req = 1'b1;
          next_state = FPC_MEM_REQ;
        end else if (key_rise[0] || (rep_fire && k_exec)) begin
          next_ir = s_data;
          next_mb = s_data;
          if (s_data[OPC_MSB:OPC_LSB] == OPC_LOAD_ACC) begin
            next_mo = ADDR_W'(s_data[OPC_LSB-1:0]);
            next_req = 1'b1;
          end
          next_op = FPC_OP_EXEC;
          next_major = FPC_EXECUTE;
          next_state = FPC_RUN_T1;
        end
      end
      FPC_MEM_REQ: begin
        if (ack_rise) begin
          next_req = 1'b0;
          next_wr = 1'b0;
          if (!wr) begin
            next_mb = m_rdata;
          end
          next_state = FPC_MEM_DONE;
        end
      end
      FPC_MEM_DONE: begin
        next_op = FPC_OP_NONE;
        next_major = FPC_FETCH;
        next_ts = TS_THREE;
        next_state = FPC_IDLE;
      end
      FPC_RUN_T1: begin
        next_ts = TS_ONE;
        if (major == FPC_FETCH) begin
          next_mo = pc;
          next_req = 1'b1;
        end
        next_state = FPC_RUN_T2;
      end
      FPC_RUN_T2: begin
        next_ts = TS_TWO;
        if (!req || ack_rise) begin
          next_req = 1'b0;
          if (req) begin
            next_mb = m_rdata;
            if (major == FPC_FETCH) begin
              next_ir = m_rdata;
            end
          end
          next_state = FPC_RUN_T3;
        end
      end
      FPC_RUN_T3: begin
        next_ts = TS_THREE;
        next_state = FPC_RUN_T1;
        if (major == FPC_FETCH) begin
          next_pc = pc + ADDR_ONE;
          next_mo = pc + ADDR_ONE;
          if (opc == OPC_JUMP) begin
            next_pc = ADDR_W'(ir[OPC_LSB-1:0]);
          end else if (opc == OPC_LOAD_ACC) begin
            next_mo = ADDR_W'(ir[OPC_LSB-1:0]);
            next_major = FPC_EXECUTE;
            next_req = 1'b1;
          end
        end else begin
          if (opc == OPC_LOAD_ACC) begin
            next_ac = mb;
          end
          next_major = FPC_FETCH;
          if (op == FPC_OP_EXEC) begin
            next_op = FPC_OP_NONE;
            next_state = FPC_IDLE;
          end
        end
        if (k_stop || stop_pend || !run) begin
          next_run = 1'b0;
          next_stop_pend = 1'b0;
          next_major = FPC_FETCH;
          next_req = 1'b0;
          if (op != FPC_OP_EXEC || major == FPC_EXECUTE) begin
            next_state = FPC_IDLE;
          end
        end
      end
      FPC_HUNG: begin
        if (k_stop && k_reset) begin
          next_run = 1'b0;
          next_state = FPC_IDLE;
          next_major = FPC_EXECUTE;
          next_ts = TS_THREE;
        end
      end
      default: next_state = FPC_IDLE;
    endcase
    next_fetch_lamp = (next_major == FPC_FETCH);
    next_execute_lamp = (next_major == FPC_EXECUTE);
  end

  // In the execute-load branch the request is raised in T3 and served in the next T2.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= FPC_IDLE;
      major <= FPC_EXECUTE;
      op <= FPC_OP_NONE;
      ts <= TS_THREE;
      run <= 1'b0;
      req <= 1'b0;
      wr <= 1'b0;
      link <= 1'b0;
      ir <= WORD_ZERO;
      mb <= WORD_ZERO;
      ac <= WORD_ZERO;
      pc <= ADDR_ZERO;
      mo <= ADDR_ZERO;
      oa <= ADDR_ZERO;
      rep_cnt <= 16'h0000;
      keys_prev <= 9'h000;
      ack_prev <= 1'b0;
      stop_pend <= 1'b0;
      fetch_lamp <= 1'b0;
      execute_lamp <= 1'b1;
    end else begin
      state <= next_state;
      major <= next_major;
      op <= next_op;
      ts <= next_ts;
      run <= next_run;
      req <= next_req;
      wr <= next_wr;
      link <= next_link;
      ir <= next_ir;
      mb <= next_mb;
      ac <= next_ac;
      pc <= next_pc;
      mo <= next_mo;
      oa <= next_oa;
      rep_cnt <= next_rep_cnt;
      keys_prev <= keys_now;
      ack_prev <= m_ack;
      stop_pend <= next_stop_pend;
      fetch_lamp <= next_fetch_lamp;
      execute_lamp <= next_execute_lamp;
    end
  end

  assign mem_request_out = req;
  assign mem_write_out = wr;
  assign mem_wdata_out = mb;
  assign memory_address_out = mo;
  assign console_address_out = oa;
  assign memory_buffer_out = mb;
  assign accumulator_out = ac;
  assign instruction_out = ir;
  assign program_counter_out = pc;
  assign link_out = link;
  assign run_out = run;
  assign fetch_lamp_out = fetch_lamp;
  assign execute_lamp_out = execute_lamp;
  assign time_state_out = ts;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence req_wait_s;
    req && !ack_rise;
  endsequence
  req_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    req_wait_s and (state == FPC_MEM_REQ) |=> req) else $error("request dropped early");
  hung_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == FPC_HUNG && !(k_stop && k_reset) |=> state == FPC_HUNG && run)
    else $error("hang released wrongly");
  hung_show_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == FPC_HUNG |-> ts == TS_TWO && major == FPC_FETCH && mb == WORD_ZERO && mo == oa)
    else $error("hang indication wrong");
  reset_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == FPC_IDLE && key_rise[8] |=> ac == WORD_ZERO && pc == ADDR_ZERO && major == FPC_EXECUTE
    && ts == TS_THREE) else $error("reset key did not clear");
  dep_load_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == FPC_IDLE && !key_rise[8] && !key_rise[7] && !key_rise[5] && key_rise[4]
    |=> mb == $past(s_data) && oa == $past(s_addr)) else $error("deposit load wrong");
  stop_rest_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == FPC_RUN_T3 && (k_stop || stop_pend) && op != FPC_OP_EXEC |=> !run && state == FPC_IDLE
    && major == FPC_FETCH) else $error("stop did not rest");
  run_idle_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    run && state inside {FPC_RUN_T1, FPC_RUN_T2} |=> oa == $past(oa))
    else $error("console op while running");
  ts_cycle_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == FPC_RUN_T1 |=> ts == TS_ONE ##1 ts == TS_TWO) else $error("time states wrong");
endmodule : fpc_console

// ===== verilog/fpc_pkg.sv
package fpc_pkg;
  localparam int WORD_W = 18;
  localparam int ADDR_W = 15;
  localparam int OPC_MSB = 17;
  localparam int OPC_LSB = 13;
  localparam logic [4:0] OPC_LOAD_ACC = 5'h0A;
  localparam logic [4:0] OPC_JUMP = 5'h1C;
  localparam logic [17:0] WORD_ZERO = 18'h00000;
  localparam logic [14:0] ADDR_ZERO = 15'h0000;
  localparam logic [14:0] ADDR_ONE = 15'h0001;
  localparam logic [1:0] TS_ONE = 2'h1;
  localparam logic [1:0] TS_TWO = 2'h2;
  localparam logic [1:0] TS_THREE = 2'h3;
  localparam logic [15:0] REPEAT_FAST = 16'h0100;
  localparam logic [15:0] REPEAT_SLOW = 16'hFFFF;
  typedef enum logic [1:0] {FPC_FETCH, FPC_EXECUTE} fpc_major_type;
  typedef enum logic [2:0] {
    FPC_OP_NONE, FPC_OP_DEP, FPC_OP_EXAM, FPC_OP_DEPN, FPC_OP_EXAMN, FPC_OP_EXEC
  } fpc_op_type;
  typedef enum logic [2:0] {
    FPC_IDLE, FPC_MEM_REQ, FPC_MEM_DONE, FPC_RUN_T1, FPC_RUN_T2, FPC_RUN_T3, FPC_HUNG
  } fpc_state_type;
endpackage : fpc_pkg

// ===== verif/fpc_mem_model.sv
`timescale 1ns/10ps
// ==========================================================
// Core memory stand-in
// The acknowledge delay is set by the bench, so both prompt and slow answers occur.
// The memory holds only 64 words, so address bits above bit 5 alias.
module fpc_mem_model (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic [fpc_pkg::WORD_W-1:0] wdata_in,
  input wire logic [fpc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [3:0] delay_in,
  output logic ack_out,
  output logic [fpc_pkg::WORD_W-1:0] rdata_out
);
  import fpc_pkg::*;
  logic [WORD_W-1:0] mem [0:63];
  logic [3:0] cnt;
  // Read data is held only with the acknowledge; at other times it toggles, so a stale read shows.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      cnt <= 4'h0;
      rdata_out <= 18'h15555;
    end else if (req_in && !ack_out && cnt >= delay_in) begin
      ack_out <= 1'b1;
      cnt <= 4'h0;
      rdata_out <= mem[addr_in[5:0]];
      if (wr_in) begin
        mem[addr_in[5:0]] <= wdata_in;
      end
    end else begin
      cnt <= (req_in && !ack_out) ? cnt + 4'h1 : 4'h0;
      ack_out <= ack_out && req_in;
      rdata_out <= (ack_out && req_in) ? rdata_out : ~rdata_out;
    end
  end
endmodule : fpc_mem_model

// ===== verif/tb.sv
`timescale 1ns/10ps
// ==========================================================
// Console bench
module tb;
  import fpc_pkg::*;
  localparam logic [14:0] TOP = 15'h003F;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sw_repeat = 1'b0;
  logic sw_slow = 1'b0;
  logic [8:0] keys = 9'h000;
  logic [14:0] sw_addr = 15'h0000;
  logic [17:0] sw_data = 18'h00000;
  logic [3:0] delay = 4'h0;
  logic [14:0] mo, oa, pc, a;
  logic [17:0] rdata, wdata, mb, ac, ir, d;
  logic req, wr, ack, link, run, fl, el;
  logic [1:0] ts;
  logic [4:0] seen;
  int n_errors = 0;
  int checks = 0;
  int i;
  fpc_console i_fpc_console (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .key_reset_in(keys[0]), .key_start_in(keys[1]), .key_stop_in(keys[2]),
    .key_continue_in(keys[3]), .key_deposit_in(keys[4]), .key_examine_in(keys[5]),
    .key_deposit_next_in(keys[6]), .key_examine_next_in(keys[7]), .key_execute_in(keys[8]),
    .sw_repeat_in(sw_repeat), .sw_speed_slow_in(sw_slow), .sw_address_in(sw_addr),
    .sw_data_in(sw_data), .mem_top_in(TOP), .mem_addr_ack_in(ack), .mem_rdata_in(rdata),
    .mem_request_out(req), .mem_write_out(wr), .mem_wdata_out(wdata),
    .memory_address_out(mo), .console_address_out(oa), .memory_buffer_out(mb),
    .accumulator_out(ac), .instruction_out(ir), .program_counter_out(pc), .link_out(link),
    .run_out(run), .fetch_lamp_out(fl), .execute_lamp_out(el), .time_state_out(ts));
  fpc_mem_model i_fpc_mem_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req),
    .wr_in(wr), .wdata_in(wdata), .addr_in(mo), .delay_in(delay), .ack_out(ack),
    .rdata_out(rdata));
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  // ==========================================================
  // Tasks
  task automatic end_sim;
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic timeout(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      $display("MISMATCH %0t wait ran out", $time);
      end_sim();
    end
  endtask : timeout
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step
  // Keys pass a two-flop synchroniser, so each is held four cycles before release.
  task automatic op(input int k);
    keys[k] = 1'b1;
    step(4);
    keys[k] = 1'b0;
    for (i = 0; i < 300 && req !== 1'b0; i++) begin
      step(1);
    end
    timeout(i, 300);
    step(4);
  endtask : op
  task automatic dep(input logic [14:0] ad, input logic [17:0] dd);
    sw_addr = ad;
    sw_data = dd;
    op(4);
  endtask : dep
  task automatic watch;
    seen = 5'h00;
    for (i = 0; i < 200; i++) begin
      step(1);
      seen = seen | {el, 4'(1 << ts)};
    end
  endtask : watch
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(28));
    step(16);
    rst_n_in = 1'b1;
    step(2);
    chk(18'({el, ts}), 18'h7, "reset lamps");
    chk(mb | ac | ir | 18'(pc) | 18'(mo) | 18'(link), 18'h0, "reset regs");
    for (int n = 0; n < 4; n++) begin
      a = 15'($urandom_range(2, 60));
      d = 18'($urandom);
      delay = 4'($urandom_range(0, 12));
      dep(a, d);
      chk(mb, d, "dep mb");
      chk(18'(oa), 18'(a), "dep oa");
      chk(18'({fl, ts}), 18'h7, "dep lamps");
      sw_data = ~d;
      op(6);
      chk(18'(oa), 18'(a + 15'h1), "depn oa");
      chk(mb, ~d, "depn mb");
      op(5);
      chk(18'(oa), 18'(a), "exam oa");
      chk(18'(mo), 18'(a), "exam mo");
      chk(mb, d, "exam mb");
      op(7);
      chk(18'(mo), 18'(a + 15'h1), "examn mo");
      chk(18'(oa), 18'(a + 15'h1), "examn oa");
      chk(mb, ~d, "examn mb");
    end
    dep(TOP - 15'h2, 18'h3FFFF);
    sw_repeat = 1'b1;
    sw_slow = 1'b1;
    keys[6] = 1'b1;
    step(600);
    chk(18'(oa), 18'(TOP - 15'h1), "slow repeat");
    sw_slow = 1'b0;
    for (i = 0; i < 3000 && ts !== TS_TWO; i++) begin
      step(1);
    end
    timeout(i, 3000);
    keys[6] = 1'b0;
    sw_repeat = 1'b0;
    step(4);
    chk(18'({run, fl, ts}), 18'hE, "hung lamps");
    chk(18'(oa), 18'(TOP + 15'h1), "hung oa");
    chk(18'(mo), 18'(TOP + 15'h1), "hung mo");
    chk(mb, 18'h0, "hung mb");
    op(2);
    op(0);
    chk(18'({run, ts}), 18'h6, "hung held");
    keys[2] = 1'b1;
    step(1);
    op(0);
    keys[2] = 1'b0;
    chk(18'({run, el, ts}), 18'h7, "hung freed");
    dep(15'h0000, {OPC_LOAD_ACC, 13'h0020});
    dep(15'h0001, {OPC_JUMP, 13'h0000});
    dep(15'h0020, 18'h2AAAA);
    a = oa;
    sw_addr = 15'h0000;
    op(1);
    sw_addr = 15'h0011;
    op(4);
    chk(18'(oa), 18'(a), "run ignores key");
    watch();
    chk(18'({run, seen}), 18'h3E, "run states");
    chk(ac, 18'h2AAAA, "run ac");
    op(2);
    chk(18'({run, fl, ts}), 18'h7, "stop lamps");
    op(3);
    watch();
    chk(18'({run, seen}), 18'h3E, "continue states");
    op(2);
    dep(15'h0021, 18'h0F0F0);
    sw_data = {OPC_LOAD_ACC, 13'h0021};
    op(8);
    chk(ac, 18'h0F0F0, "execute ac");
    chk(ir, {OPC_LOAD_ACC, 13'h0021}, "execute ir");
    end_sim();
  end
endmodule : tb
